// ==== design/uart_rx_map.svh ====
// offsets-free constants for the receive enhancement block: modes, reset values, timing
`ifndef UART_RX_MAP_SVH
`define UART_RX_MAP_SVH
`define MODE_SHIFT 2'h0
`define MODE_UART8 2'h1
`define MODE_UART9 2'h2
`define MODE_UART9V 2'h3
`define NODE_ADDR_RST 8'h00
`define NODE_MASK_RST 8'h00
`define OVERSAMPLE 16
`define BAUD_DIV_RST 16'h001b
`define FIFO_DEPTH 16
`endif

// ==== design/uart_rx_pkg.sv ====
// types shared by the receive enhancement block
package uart_rx_pkg;
  typedef enum logic [2:0] {
    st_idle = 3'b000,
    st_start = 3'b001,
    st_data = 3'b010,
    st_ninth = 3'b011,
    st_stop = 3'b100
  } rx_state_t;
  typedef struct packed {
    logic [7:0] data;
    logic ninth;
    logic frame_err;
  } rx_word_t;
endpackage

// ==== design/rx_fifo_mem.sv ====
// small register-file memory for the receive fifo, registered read data
`timescale 1ns/1ns
module rx_fifo_mem #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 16,
  parameter int AW = $clog2(DEPTH)
) (
  // clock
  input wire logic ref_clk,
  // write side
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // read side
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  always_ff @(posedge ref_clk)
  begin
    if (wr_en)
    begin
      mem_q[wr_addr] <= wr_data;
    end
    rd_data <= mem_q[rd_addr];
  end
endmodule

// ==== design/rx_fifo.sv ====
// valid/ready fifo in front of the receive data consumer
`timescale 1ns/1ns
module rx_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [AW:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0] count;
  logic [AW:0] occ;
  logic [AW-1:0] rd_addr;
  logic outv_q, outv_d;
  logic [WIDTH-1:0] rd_data;
  logic push, pop;
  assign count = wp_q - rp_q;
  // the word held at the output still owns its slot until it leaves
  assign occ = count + {{AW{1'b0}}, outv_q};
  assign in_ready = occ != DEPTH[AW:0];
  assign push = in_valid && in_ready;
  // one-entry output stage: the memory read takes a cycle, so data follow pop by one
  assign pop = (count != '0) && (!outv_q || out_ready);
  // re-read the held word while stalled so the output data stand
  assign rd_addr = pop ? rp_q[AW-1:0] : rp_q[AW-1:0] - AW'(1);
  always_comb
  begin
    wp_d = push ? wp_q + 1'b1 : wp_q;
    rp_d = pop ? rp_q + 1'b1 : rp_q;
    outv_d = pop ? 1'b1 : (out_ready ? 1'b0 : outv_q);
  end
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      wp_q <= '0;
      rp_q <= '0;
      outv_q <= 1'b0;
    end
    else
    begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      outv_q <= outv_d;
    end
  end
  rx_fifo_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_mem (
    .ref_clk(ref_clk),
    .wr_en(push),
    .wr_addr(wp_q[AW-1:0]),
    .wr_data(in_data),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );
  assign out_valid = outv_q;
  assign out_data = rd_data;
endmodule

// ==== design/uart_frame_check_addr_match.sv ====
// serial receiver with stop-bit check and hardware address recognition
// Notes on behaviour
// R1: stop-bit checking exists only in modes 1, 2 and 3 and only while frame_check_enable is set.
// R2: with checking on, each frame's stop bit is sampled and a low stop bit sets the error flag.
// R3: the framing error flag stays set until software clears it or reset; good frames keep it.
// R4: with checking on, the receive-done flag rises at the stop bit, not at the last data bit.
// R5: address recognition runs exactly while multiprocessor_enable is set in modes 1, 2 and 3.
// R6: while recognition runs, an address frame raises receive-done only if its address matches.
// R7: in mode 1 with recognition, the stop bit is the ninth bit and must be valid to raise done.
// R8: in mode 0 multiprocessor_enable has no effect at all.
// R9: the individual match compares only bit positions where the mask holds one.
// R10: a mask of all ones demands an exact eight-bit match with the node address.
// R11: the broadcast address is node address OR mask, with its zero bits as don't-care.
// R12: an address frame is accepted if it matches the individual or the broadcast address.
// R13: receiver and transmitter are independent; this receiver keeps its own baud timing.
// R14: a master reaching all nodes normally sends the all-ones address.
// R15: after reset node address and mask are zero, so every address is accepted.
// R16: in mode 1 with multiprocessor off the ninth-bit flag takes the stop bit; unused in mode 0.
// R17: in modes 2 and 3 a ninth bit of one marks an address frame; data frames are filtered out only while multiprocessor_enable is set.
`timescale 1ns/1ns
`include "uart_rx_map.svh"
module uart_frame_check_addr_match #(
  parameter int OVERSAMPLE = `OVERSAMPLE,
  parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // serial line
  input wire logic rx_line,
  // control bits
  input wire logic [1:0] serial_mode,
  input wire logic receive_enable,
  input wire logic multiprocessor_enable,
  input wire logic frame_check_enable,
  input wire logic [15:0] baud_div,
  // address registers written by software
  input wire logic node_address_we,
  input wire logic [7:0] node_address_wdata,
  input wire logic node_address_mask_we,
  input wire logic [7:0] node_address_mask_wdata,
  // flag clears from software
  input wire logic framing_error_clear,
  input wire logic receive_done_clear,
  // status
  output logic framing_error_flag,
  output logic receive_done_flag,
  output logic received_ninth_bit,
  output logic [7:0] node_address,
  output logic [7:0] node_address_mask,
  // received words
  output logic rx_valid,
  input wire logic rx_ready,
  output uart_rx_pkg::rx_word_t rx_word
);
  //////////////////////////////////////////////////////////////////////////////
  // address registers and matching
  logic [7:0] addr_q, addr_d, mask_q, mask_d;
  logic [7:0] bcast;
  logic [7:0] shift_q, shift_d;
  logic hit_given, hit_bcast, addr_hit;
  always_comb
  begin
    addr_d = node_address_we ? node_address_wdata : addr_q;
    mask_d = node_address_mask_we ? node_address_mask_wdata : mask_q;
  end
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      addr_q <= `NODE_ADDR_RST; // [R15]
      mask_q <= `NODE_MASK_RST; // [R15]
    end
    else
    begin
      addr_q <= addr_d;
      mask_q <= mask_d;
    end
  end
  assign node_address = addr_q;
  assign node_address_mask = mask_q;
  assign bcast = addr_q | mask_q; // [R11]
  // masked compare; an all-ones mask leaves an exact compare
  assign hit_given = ((shift_q ^ addr_q) & mask_q) == 8'h00; // [R9] [R10]
  // zero bits of the broadcast address are don't-care
  assign hit_bcast = ((shift_q ^ bcast) & bcast) == 8'h00; // [R11]
  assign addr_hit = hit_given || hit_bcast; // [R12]

  //////////////////////////////////////////////////////////////////////////////
  // receive sequencer
  // timing is the receiver's own; the transmitter is elsewhere and never shares it [R13]
  uart_rx_pkg::rx_state_t st_q, st_d;
  logic [15:0] div_q, div_d;
  logic [4:0] tick_q, tick_d;
  logic [2:0] bit_q, bit_d;
  logic ninth_q, ninth_d;
  logic tick, mid, async_mode, nine_bit, mp_on;
  logic stop_ok, frame_end;
  logic fe_q, fe_d, done_q, done_d, rb8_q, rb8_d;
  logic push_q, push_d;
  uart_rx_pkg::rx_word_t word_q, word_d;
  logic fifo_ready;
  logic accept;

  assign async_mode = serial_mode != `MODE_SHIFT;
  assign nine_bit = serial_mode == `MODE_UART9 || serial_mode == `MODE_UART9V;
  assign mp_on = multiprocessor_enable && async_mode; // [R5] [R8]
  assign tick = div_q == 16'h0000;
  assign mid = tick && tick_q == 5'(OVERSAMPLE / 2 - 1);
  assign stop_ok = rx_line;

  always_comb
  begin
    div_d = tick ? baud_div : div_q - 16'h0001;
    tick_d = tick_q;
    bit_d = bit_q;
    st_d = st_q;
    shift_d = shift_q;
    ninth_d = ninth_q;
    frame_end = 1'b0;
    case (st_q)
      uart_rx_pkg::st_idle:
      begin
        tick_d = 5'h00;
        if (receive_enable && !rx_line)
        begin
          st_d = uart_rx_pkg::st_start;
        end
      end
      uart_rx_pkg::st_start:
      begin
        if (tick)
        begin
          tick_d = tick_q + 5'h01;
        end
        if (mid)
        begin
          tick_d = 5'h00;
          bit_d = 3'h0;
          st_d = rx_line ? uart_rx_pkg::st_idle : uart_rx_pkg::st_data;
        end
      end
      uart_rx_pkg::st_data:
      begin
        if (tick)
        begin
          tick_d = tick_q + 5'h01;
        end
        if (tick && tick_q == 5'(OVERSAMPLE - 1))
        begin
          tick_d = 5'h00;
          shift_d = {rx_line, shift_q[7:1]};
          bit_d = bit_q + 3'h1;
          if (bit_q == 3'h7)
          begin
            st_d = nine_bit ? uart_rx_pkg::st_ninth : uart_rx_pkg::st_stop;
          end
        end
      end
      uart_rx_pkg::st_ninth:
      begin
        if (tick)
        begin
          tick_d = tick_q + 5'h01;
        end
        if (tick && tick_q == 5'(OVERSAMPLE - 1))
        begin
          tick_d = 5'h00;
          ninth_d = rx_line;
          st_d = uart_rx_pkg::st_stop;
        end
      end
      uart_rx_pkg::st_stop:
      begin
        if (tick)
        begin
          tick_d = tick_q + 5'h01;
        end
        if (tick && tick_q == 5'(OVERSAMPLE - 1))
        begin
          // stop bit sampled at its centre [R2] [R4]
          frame_end = 1'b1;
          st_d = uart_rx_pkg::st_idle;
        end
      end
      default:
      begin
        st_d = uart_rx_pkg::st_idle;
      end
    endcase
  end

  // mode 0 is shift-register only and is not received here; the flag then stays 0
  always_comb
  begin
    accept = 1'b0;
    if (async_mode)
    begin
      if (!mp_on)
      begin
        accept = 1'b1; // [R8]
      end
      else if (nine_bit)
      begin
        accept = ninth_q && addr_hit; // [R6] [R17]
      end
      else
      begin
        accept = stop_ok && addr_hit; // [R7]
      end
    end
  end

  always_comb
  begin
    fe_d = fe_q;
    if (framing_error_clear)
    begin
      fe_d = 1'b0;
    end
    // set beats a same-cycle clear
    if (frame_end && frame_check_enable && async_mode && !stop_ok)
    begin
      fe_d = 1'b1; // [R1] [R2] [R3]
    end
    done_d = done_q;
    if (receive_done_clear)
    begin
      done_d = 1'b0;
    end
    // done waits for the stop bit in every case, which meets the checked-mode timing [R4]
    if (frame_end && accept)
    begin
      done_d = 1'b1; // [R6]
    end
    rb8_d = rb8_q;
    if (frame_end && accept)
    begin
      rb8_d = nine_bit ? ninth_q : stop_ok; // [R16]
    end
    word_d = word_q;
    push_d = 1'b0;
    if (frame_end && accept)
    begin
      word_d.data = shift_q;
      word_d.ninth = nine_bit ? ninth_q : stop_ok;
      word_d.frame_err = frame_check_enable && !stop_ok;
      // a word that meets a full queue is lost, as an overrun would lose it
      push_d = fifo_ready;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      st_q <= uart_rx_pkg::st_idle;
      div_q <= 16'h0000;
      tick_q <= 5'h00;
      bit_q <= 3'h0;
      shift_q <= 8'h00;
      ninth_q <= 1'b0;
      fe_q <= 1'b0;
      done_q <= 1'b0;
      rb8_q <= 1'b0;
      word_q <= '0;
      push_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      div_q <= div_d;
      tick_q <= tick_d;
      bit_q <= bit_d;
      shift_q <= shift_d;
      ninth_q <= ninth_d;
      fe_q <= fe_d;
      done_q <= done_d;
      rb8_q <= rb8_d;
      word_q <= word_d;
      push_q <= push_d;
    end
  end

  assign framing_error_flag = fe_q;
  assign receive_done_flag = done_q;
  assign received_ninth_bit = rb8_q;

  //////////////////////////////////////////////////////////////////////////////
  // accepted words queue up; a full queue drops the newest word, as an overrun would
  rx_fifo #(.WIDTH($bits(uart_rx_pkg::rx_word_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .srst(srst),
    .in_valid(push_q),
    .in_ready(fifo_ready),
    .in_data(word_q),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(rx_word)
  );
endmodule

// ==== test/uart_frame_check_addr_match_properties.sv ====
// port-level assertions for the receive enhancement block
`timescale 1ns/1ns
module uart_frame_check_addr_match_checker (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // control inputs
  input wire logic rx_line,
  input wire logic [1:0] serial_mode,
  input wire logic multiprocessor_enable,
  input wire logic frame_check_enable,
  input wire logic framing_error_clear,
  input wire logic receive_done_clear,
  // status outputs and the receive handshake
  input wire logic framing_error_flag,
  input wire logic receive_done_flag,
  input wire logic received_ninth_bit,
  input wire logic [7:0] node_address,
  input wire logic [7:0] node_address_mask,
  input wire logic rx_valid,
  input wire logic rx_ready
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////////////////////
  chk_fe_sticky: assert property (framing_error_flag && !framing_error_clear
    |=> framing_error_flag)
    else $error("framing error flag dropped without clear");
  chk_done_sticky: assert property (receive_done_flag && !receive_done_clear
    |=> receive_done_flag)
    else $error("receive done flag dropped without clear");
  chk_addr_reset: assert property ($past(srst)
    |-> node_address == 8'h00 && node_address_mask == 8'h00)
    else $error("address registers not zero after reset");
  chk_mode0_quiet: assert property (serial_mode == 2'h0 && $past(serial_mode) == 2'h0
    |-> !$rose(receive_done_flag))
    else $error("receive done raised in shift mode");
  chk_check_off: assert property (!frame_check_enable && !$past(frame_check_enable)
    |-> !$rose(framing_error_flag))
    else $error("framing error set with checking off");
  chk_fe_cause: assert property ($rose(framing_error_flag)
    |-> serial_mode != 2'h0 && !$past(rx_line))
    else $error("framing error set without a low stop bit");
  chk_mode1_stop: assert property ($rose(receive_done_flag) && serial_mode == 2'h1
    && multiprocessor_enable |-> $past(rx_line))
    else $error("mode 1 address frame accepted with a bad stop bit");
  chk_ninth_stop: assert property ($rose(receive_done_flag) && serial_mode == 2'h1
    && !multiprocessor_enable |-> received_ninth_bit == $past(rx_line))
    else $error("ninth bit flag does not hold the stop bit");
  cover property ($rose(receive_done_flag));
  cover property ($rose(framing_error_flag));
  cover property ((rx_valid && !rx_ready) [*2]);
endmodule
bind uart_frame_check_addr_match uart_frame_check_addr_match_checker u_chk (
  .ref_clk, .srst, .rx_line, .serial_mode, .multiprocessor_enable, .frame_check_enable,
  .framing_error_clear, .receive_done_clear, .framing_error_flag, .receive_done_flag,
  .received_ninth_bit, .node_address, .node_address_mask, .rx_valid, .rx_ready
);

// ==== test/uart_peer_model.sv ====
// far-side serial sender on the shared line, idle high
`timescale 1ns/1ns
module uart_peer_model #(
  parameter int BIT_CLKS = 16
) (
  // clock
  input wire logic ref_clk,
  // shared serial line
  output logic line
);
  initial line = 1'b1;
  task automatic put(input logic b);
    line <= b;
    repeat (BIT_CLKS) @(posedge ref_clk);
  endtask
  // lsb first; a trailing idle bit keeps a bad stop from looking like a start
  task automatic send(input logic [7:0] d, input logic nine, input logic has_nine,
    input logic stop);
    @(posedge ref_clk);
    put(1'b0);
    for (int i = 0; i < 8; i++)
      put(d[i]);
    if (has_nine)
      put(nine);
    put(stop);
    put(1'b1);
  endtask
endmodule

// ==== test/uart_frame_check_addr_match_tb_top.sv ====
// self-checking bench for the receive enhancement block
`timescale 1ns/1ns
module uart_frame_check_addr_match_tb_top;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic rx_line;
  logic [1:0] serial_mode = 2'h2;
  logic receive_enable = 1'b1;
  logic multiprocessor_enable = 1'b0;
  logic frame_check_enable = 1'b0;
  logic node_address_we = 1'b0;
  logic [7:0] node_address_wdata = 8'h00;
  logic node_address_mask_we = 1'b0;
  logic [7:0] node_address_mask_wdata = 8'h00;
  logic framing_error_clear = 1'b0;
  logic receive_done_clear = 1'b0;
  logic framing_error_flag, receive_done_flag, received_ninth_bit, rx_valid;
  logic rx_ready = 1'b1;
  logic [7:0] node_address, node_address_mask;
  uart_rx_pkg::rx_word_t rx_word;
  int fails = 0;
  int total_checks = 0;
  int cycles = 0;
  int n;
  // row: mode, mp, check, byte, ninth, stop, expected done, expected error
  logic [15:0] rows [10] = '{
    {2'h2, 1'h1, 1'h0, 8'hf0, 1'h1, 1'h1, 1'h1, 1'h0},
    {2'h2, 1'h1, 1'h0, 8'hf2, 1'h1, 1'h1, 1'h0, 1'h0},
    {2'h3, 1'h1, 1'h0, 8'hff, 1'h1, 1'h1, 1'h1, 1'h0},
    {2'h3, 1'h1, 1'h0, 8'hfb, 1'h1, 1'h1, 1'h1, 1'h0},
    {2'h2, 1'h1, 1'h0, 8'hf0, 1'h0, 1'h1, 1'h0, 1'h0},
    {2'h1, 1'h1, 1'h1, 8'hf0, 1'h0, 1'h1, 1'h1, 1'h0},
    {2'h1, 1'h1, 1'h1, 8'hf0, 1'h0, 1'h0, 1'h0, 1'h1},
    {2'h1, 1'h0, 1'h1, 8'h3c, 1'h0, 1'h0, 1'h1, 1'h1},
    {2'h2, 1'h0, 1'h0, 8'h3c, 1'h0, 1'h0, 1'h1, 1'h0},
    {2'h0, 1'h1, 1'h1, 8'hf0, 1'h1, 1'h1, 1'h0, 1'h0}};
  always #10 ref_clk = ~ref_clk;
  uart_peer_model #(.BIT_CLKS(16)) u_peer (.ref_clk(ref_clk), .line(rx_line));
  uart_frame_check_addr_match u_dut (
    .ref_clk(ref_clk), .srst(srst), .rx_line(rx_line), .serial_mode(serial_mode),
    .receive_enable(receive_enable), .multiprocessor_enable(multiprocessor_enable),
    .frame_check_enable(frame_check_enable), .baud_div(16'h0000),
    .node_address_we(node_address_we), .node_address_wdata(node_address_wdata),
    .node_address_mask_we(node_address_mask_we),
    .node_address_mask_wdata(node_address_mask_wdata),
    .framing_error_clear(framing_error_clear), .receive_done_clear(receive_done_clear),
    .framing_error_flag(framing_error_flag), .receive_done_flag(receive_done_flag),
    .received_ninth_bit(received_ninth_bit), .node_address(node_address),
    .node_address_mask(node_address_mask), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rx_word(rx_word));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    if (fails == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic set_addr(input logic [7:0] a, input logic [7:0] m);
    node_address_we <= 1'b1;
    node_address_wdata <= a;
    node_address_mask_we <= 1'b1;
    node_address_mask_wdata <= m;
    @(posedge ref_clk);
    node_address_we <= 1'b0;
    node_address_mask_we <= 1'b0;
    @(posedge ref_clk);
  endtask
  // one frame, then flag checks; clr=0 leaves the flags set for the next frame
  task automatic frame(input logic [15:0] r, input logic clr);
    @(posedge ref_clk);
    serial_mode <= r[15:14];
    multiprocessor_enable <= r[13];
    frame_check_enable <= r[12];
    u_peer.send(r[11:4], r[3], r[15], r[2]);
    repeat (4) @(posedge ref_clk);
    chk(8'(receive_done_flag), 8'(r[1]));
    chk(8'(framing_error_flag), 8'(r[0]));
    receive_done_clear <= clr;
    framing_error_clear <= clr;
    @(posedge ref_clk);
    receive_done_clear <= 1'b0;
    framing_error_clear <= 1'b0;
    @(posedge ref_clk);
  endtask
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    chk(node_address, 8'h00);
    chk(node_address_mask, 8'h00);
    frame({2'h2, 1'h1, 1'h0, 8'h3c, 1'h1, 1'h1, 1'h1, 1'h0}, 1'b1);
    // node f1 with mask fa: given 1111_0x0x, broadcast 1111_1x11
    set_addr(8'hf1, 8'hfa);
    chk(node_address_mask, 8'hfa);
    for (int i = 0; i < 10; i++)
      frame(rows[i], 1'b1);
    frame({2'h1, 1'h0, 1'h1, 8'h11, 1'h0, 1'h0, 1'h1, 1'h1}, 1'b0);
    chk(8'(received_ninth_bit), 8'h00);
    frame({2'h1, 1'h0, 1'h1, 8'h22, 1'h0, 1'h1, 1'h1, 1'h1}, 1'b1);
    chk(8'(received_ninth_bit), 8'h01);
    set_addr(8'hf1, 8'hff);
    // broadcast is now all ones, so the all-call address still reaches this node
    frame({2'h2, 1'h1, 1'h0, 8'hff, 1'h1, 1'h1, 1'h1, 1'h0}, 1'b1);
    frame({2'h2, 1'h1, 1'h0, 8'hf1, 1'h1, 1'h1, 1'h1, 1'h0}, 1'b1);
    frame({2'h2, 1'h1, 1'h0, 8'hf3, 1'h1, 1'h1, 1'h0, 1'h0}, 1'b1);
    // consumer stalls while 18 words arrive; only the fifo depth survives
    rx_ready <= 1'b0;
    for (int i = 0; i < 18; i++)
      frame({2'h3, 1'h0, 1'h0, 8'(i), 1'h0, 1'h1, 1'h1, 1'h0}, 1'b1);
    rx_ready <= 1'b1;
    n = 0;
    repeat (80)
    begin
      @(posedge ref_clk);
      if (rx_valid && rx_ready)
      begin
        chk(rx_word.data, 8'(n));
        chk(8'(rx_word.ninth), 8'h00);
        chk(8'(rx_word.frame_err), 8'h00);
        n++;
      end
    end
    chk(8'(n), 8'h10);
    // a reset in mid-run clears a standing framing error and the address registers
    frame({2'h1, 1'h0, 1'h1, 8'h55, 1'h0, 1'h0, 1'h1, 1'h1}, 1'b0);
    srst <= 1'b1;
    @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    chk(8'(framing_error_flag), 8'h00);
    chk(node_address, 8'h00);
    chk(node_address_mask, 8'h00);
    end_sim();
  end
endmodule
